// *** rtl/sfwp_regs.svh ***
// Opcodes, status bit positions, counts and host register map
// Included by both ends of the serial flash protection link
`ifndef SFWP_REGS_SVH
`define SFWP_REGS_SVH

// Link opcodes
`define SFWP_OP_LATCH_SET 8'h06
`define SFWP_OP_LATCH_CLR 8'h04
`define SFWP_OP_STAT_WR 8'h01
`define SFWP_OP_STAT_RD 8'h05
`define SFWP_OP_PROG 8'h02
`define SFWP_OP_PAGE_ERASE 8'h81
`define SFWP_OP_ERASE_4K 8'h20
`define SFWP_OP_ERASE_32K_A 8'h52
`define SFWP_OP_ERASE_32K_B 8'hD8
`define SFWP_OP_CHIP_A 8'h60
`define SFWP_OP_CHIP_B 8'h62
`define SFWP_OP_CHIP_C 8'hC7
`define SFWP_OP_OTP 8'h9B

// Status byte bit positions
`define SFWP_SR_BUSY 3'h0
`define SFWP_SR_LATCH 3'h1
`define SFWP_SR_PROT 3'h2
`define SFWP_SR_LOCK 3'h7

// Least whole bytes per command, opcode included; byte and bit count ends
`define SFWP_N_STAT 3'h2
`define SFWP_N_PROG 3'h5
`define SFWP_N_ERASE 3'h4
`define SFWP_N_CHIP 3'h1
`define SFWP_BYTE_SAT 3'h7
`define SFWP_BIT_LAST 3'h7

// Protected window while the array protect bit is set
`define SFWP_PROT_LAST 24'h00FFFF

// Host register map and fields
`define SFWP_A_CMD0 4'h0
`define SFWP_A_CMD1 4'h4
`define SFWP_A_STAT 4'h8
`define SFWP_A_WP 4'hC
`define SFWP_CMD1_BITS_LO 4'h8
`define SFWP_HOST_DIV 3'h3
`define SFWP_RESP_OKAY 2'h0
`define SFWP_RESP_SLVERR 2'h2

`endif

// *** rtl/sfwp_pkg.sv ***
// Types shared by both ends of the protection link
// Assumes sfwp_regs.svh for the numeric constants
package sfwp_pkg;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_LEAD = 2'h1,
    H_SHIFT = 2'h3,
    H_TRAIL = 2'h2
  } sfwp_host_e;

  typedef enum logic {
    D_IDLE = 1'h0,
    D_BUSY = 1'h1
  } sfwp_dev_e;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_PROG = 3'h1,
    K_ERASE = 3'h2,
    K_CHIP = 3'h3,
    K_OTP = 3'h4
  } sfwp_kind_e;

endpackage

// *** rtl/sfwp_if.sv ***
// Serial link between the host controller and the flash device
// Assumes both ends run on the same aclk
`timescale 1ns/1ps
interface sfwp_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic wp_n;
  logic miso;
  logic miso_oe_n;
  logic miso_line;

  // Undriven data line reads high
  assign miso_line = miso_oe_n ? 1'h1 : miso;

  modport dev (
    input cs_n,
    input sclk,
    input mosi,
    input wp_n,
    output miso,
    output miso_oe_n
  );

  modport host (
    output cs_n,
    output sclk,
    output mosi,
    output wp_n,
    input miso_line
  );
endinterface

// *** rtl/sfwp_device.sv ***
// Flash device end: write latch, array protect and lock bits
// Assumes link pins come from host flops on the same aclk
//
// How it works
// R01 - Latch-set opcode sets latch at select rise
// R02 - Latch-clear opcode clears latch at select rise
// R03 - Modifying commands need latch already set
// R04 - Latch opcodes ignore any trailing bytes
// R05 - Partial byte or short opcode aborts
// R06 - Protect bit blocks program and erase
// R07 - Protect bit changes only by status write
// R08 - Protect bit kept nonvolatile, shipped clear
// R09 - Locked when pin low and lock set
// R10 - Lock freezes bits, ignores status write
// R11 - Pin high: lock may set, no freeze
// R12 - Lock clears only with pin high
// R13 - Lock cleared by power cycle or status write
// R14 - Pin acts only through the lock
// R15 - Host raises pin before clearing lock
// R16 - Host leaves protect set before power-off
// R17 - Latch cleared before self-timed cycle ends
// R18 - Protected target skipped, latch cleared
// R19 - Latch clear at power-up
`timescale 1ns/1ps
`include "sfwp_regs.svh"
module sfwp_device
  import sfwp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link
  sfwp_if.dev ifc,
  // Nonvolatile cell for the protect bit
  input wire logic nv_prot_in,
  output logic nv_wr,
  output logic nv_wr_val,
  // Self-timed operation control
  output logic op_start,
  output sfwp_kind_e op_kind,
  output logic [23:0] op_addr,
  input wire logic op_done,
  // State view
  output logic write_latch_flag,
  output logic array_protect_bit,
  output logic protect_lock_bit,
  output logic hw_locked
);

  sfwp_dev_e st_r, st_nxt;
  logic cs_q_r, cs_q_nxt;
  logic sclk_q_r, sclk_q_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [2:0] byte_cnt_r, byte_cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] op_r, op_nxt;
  logic [7:0] sdata_r, sdata_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic latch_r, latch_nxt;
  logic prot_r, prot_nxt;
  logic lock_r, lock_nxt;
  logic lockd_r, lockd_nxt;
  logic miso_r, miso_nxt;
  logic oe_n_r, oe_n_nxt;
  logic start_r, start_nxt;
  sfwp_kind_e kind_r, kind_nxt;
  logic [23:0] oaddr_r, oaddr_nxt;
  logic nvw_r, nvw_nxt;
  logic nvv_r, nvv_nxt;

  logic rise;
  logic fall;
  logic sel_start;
  logic sel_end;
  logic locked;
  logic complete;
  logic [7:0] in_byte;
  logic [7:0] stat_v;

  assign rise = !ifc.cs_n && !sclk_q_r && ifc.sclk;
  assign fall = !ifc.cs_n && sclk_q_r && !ifc.sclk;
  assign sel_start = !ifc.cs_n && cs_q_r;
  assign sel_end = ifc.cs_n && !cs_q_r;
  // Pin low and lock set, nothing else [R09] [R14]
  assign locked = !ifc.wp_n && lock_r;
  // Whole bytes only, opcode included [R05]
  assign complete = (bit_cnt_r == 3'h0) && (byte_cnt_r != 3'h0);
  assign in_byte = {shift_r[6:0], ifc.mosi};

  always_comb begin
    stat_v = 8'h00;
    stat_v[`SFWP_SR_BUSY] = (st_r == D_BUSY);
    stat_v[`SFWP_SR_LATCH] = latch_r;
    stat_v[`SFWP_SR_PROT] = prot_r;
    stat_v[`SFWP_SR_LOCK] = lock_r;
  end

  always_comb begin : next_state
    logic is_mod;
    logic hit;
    logic [2:0] need;
    sfwp_kind_e kind;
    is_mod = 1'h0;
    hit = 1'h0;
    need = `SFWP_N_CHIP;
    kind = K_NONE;
    st_nxt = st_r;
    cs_q_nxt = ifc.cs_n;
    sclk_q_nxt = ifc.sclk;
    bit_cnt_nxt = bit_cnt_r;
    byte_cnt_nxt = byte_cnt_r;
    shift_nxt = shift_r;
    op_nxt = op_r;
    sdata_nxt = sdata_r;
    addr_nxt = addr_r;
    latch_nxt = latch_r;
    prot_nxt = prot_r;
    lock_nxt = lock_r;
    lockd_nxt = locked;
    miso_nxt = miso_r;
    oe_n_nxt = oe_n_r;
    start_nxt = 1'h0;
    kind_nxt = kind_r;
    oaddr_nxt = oaddr_r;
    nvw_nxt = 1'h0;
    nvv_nxt = nvv_r;
    if (sel_start) begin
      bit_cnt_nxt = 3'h0;
      byte_cnt_nxt = 3'h0;
      // No opcode carried over from the last frame [R05]
      op_nxt = 8'h00;
    end
    if (rise) begin
      shift_nxt = in_byte;
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (bit_cnt_r == `SFWP_BIT_LAST) begin
        // Bytes past the ones decoded fall through unused [R04]
        if (byte_cnt_r != `SFWP_BYTE_SAT) begin
          byte_cnt_nxt = byte_cnt_r + 3'h1;
        end
        case (byte_cnt_r)
          3'h0: op_nxt = in_byte;
          3'h1: begin
            addr_nxt[23:16] = in_byte;
            sdata_nxt = in_byte;
          end
          3'h2: addr_nxt[15:8] = in_byte;
          3'h3: addr_nxt[7:0] = in_byte;
          default: ;
        endcase
      end
    end
    // Status byte out, MSB first
    if (fall && op_r == `SFWP_OP_STAT_RD && byte_cnt_r != 3'h0) begin
      miso_nxt = stat_v[~bit_cnt_r];
      oe_n_nxt = 1'h0;
    end
    if (st_r == D_BUSY && op_done) begin
      st_nxt = D_IDLE;
    end
    if (sel_end) begin
      miso_nxt = 1'h1;
      oe_n_nxt = 1'h1;
    end
    if (sel_end && st_r == D_IDLE) begin
      case (op_r)
        `SFWP_OP_LATCH_SET: begin
          if (complete) begin
            latch_nxt = 1'h1; // [R01]
          end
        end
        `SFWP_OP_LATCH_CLR: begin
          if (complete) begin
            latch_nxt = 1'h0; // [R02]
          end
        end
        `SFWP_OP_STAT_WR: begin
          // Only path that changes either protection bit [R07] [R10]
          if (latch_r && !locked) begin
            latch_nxt = 1'h0;
            if (complete && byte_cnt_r >= `SFWP_N_STAT) begin
              // Unlocked lock bit may go either way [R11] [R12]
              prot_nxt = sdata_r[`SFWP_SR_PROT];
              lock_nxt = sdata_r[`SFWP_SR_LOCK];
              nvw_nxt = 1'h1; // [R08]
              nvv_nxt = sdata_r[`SFWP_SR_PROT];
            end
          end
        end
        `SFWP_OP_PROG: begin
          is_mod = 1'h1;
          need = `SFWP_N_PROG;
          kind = K_PROG;
          hit = prot_r && (addr_r <= `SFWP_PROT_LAST); // [R06]
        end
        `SFWP_OP_PAGE_ERASE, `SFWP_OP_ERASE_4K,
        `SFWP_OP_ERASE_32K_A, `SFWP_OP_ERASE_32K_B: begin
          is_mod = 1'h1;
          need = `SFWP_N_ERASE;
          kind = K_ERASE;
          hit = prot_r && (addr_r <= `SFWP_PROT_LAST); // [R06]
        end
        `SFWP_OP_CHIP_A, `SFWP_OP_CHIP_B, `SFWP_OP_CHIP_C: begin
          is_mod = 1'h1;
          need = `SFWP_N_CHIP;
          kind = K_CHIP;
          hit = prot_r; // [R06]
        end
        `SFWP_OP_OTP: begin
          is_mod = 1'h1;
          need = `SFWP_N_PROG;
          kind = K_OTP;
        end
        default: ;
      endcase
      // Nothing happens without the latch [R03]
      if (is_mod && latch_r) begin
        // Cleared at start, so before the cycle ends [R17] [R18]
        latch_nxt = 1'h0;
        if (complete && byte_cnt_r >= need && !hit) begin
          start_nxt = 1'h1;
          kind_nxt = kind;
          oaddr_nxt = addr_r;
          st_nxt = D_BUSY;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= D_IDLE;
      cs_q_r <= 1'h1;
      sclk_q_r <= 1'h0;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      op_r <= 8'h00;
      sdata_r <= 8'h00;
      addr_r <= 24'h000000;
      latch_r <= 1'h0; // [R19]
      prot_r <= nv_prot_in; // [R08]
      lock_r <= 1'h0; // [R13]
      lockd_r <= 1'h0;
      miso_r <= 1'h1;
      oe_n_r <= 1'h1;
      start_r <= 1'h0;
      kind_r <= K_NONE;
      oaddr_r <= 24'h000000;
      nvw_r <= 1'h0;
      nvv_r <= 1'h0;
    end else begin
      st_r <= st_nxt;
      cs_q_r <= cs_q_nxt;
      sclk_q_r <= sclk_q_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      shift_r <= shift_nxt;
      op_r <= op_nxt;
      sdata_r <= sdata_nxt;
      addr_r <= addr_nxt;
      latch_r <= latch_nxt;
      prot_r <= prot_nxt;
      lock_r <= lock_nxt;
      lockd_r <= lockd_nxt;
      miso_r <= miso_nxt;
      oe_n_r <= oe_n_nxt;
      start_r <= start_nxt;
      kind_r <= kind_nxt;
      oaddr_r <= oaddr_nxt;
      nvw_r <= nvw_nxt;
      nvv_r <= nvv_nxt;
    end
  end

  assign ifc.miso = miso_r;
  assign ifc.miso_oe_n = oe_n_r;
  assign nv_wr = nvw_r;
  assign nv_wr_val = nvv_r;
  assign op_start = start_r;
  assign op_kind = kind_r;
  assign op_addr = oaddr_r;
  assign write_latch_flag = latch_r;
  assign array_protect_bit = prot_r;
  assign protect_lock_bit = lock_r;
  assign hw_locked = lockd_r;

endmodule

// *** rtl/sfwp_host.sv ***
// Host controller end: AXI4-Lite registers drive the serial link
// Assumes the device end shares aclk; mode 0, clock idles low
`timescale 1ns/1ps
`include "sfwp_regs.svh"
module sfwp_host
  import sfwp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Link
  sfwp_if.host ifc
);

  sfwp_host_e st_r, st_nxt;
  logic aw_h_r, aw_h_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic [3:0] aw_a_r, aw_a_nxt;
  logic w_h_r, w_h_nxt;
  logic [31:0] w_d_r, w_d_nxt;
  logic [3:0] w_s_r, w_s_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] cmd0_r, cmd0_nxt;
  logic [31:0] cmd1_r, cmd1_nxt;
  logic wp_n_r, wp_n_nxt;
  logic [39:0] tx_r, tx_nxt;
  logic [5:0] bits_r, bits_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic [2:0] div_r, div_nxt;
  logic cs_n_r, cs_n_nxt;
  logic sclk_r, sclk_nxt;
  logic mosi_r, mosi_nxt;

  logic tick;
  logic busy;
  logic [31:0] stat_v;

  assign tick = (div_r == `SFWP_HOST_DIV);
  assign busy = (st_r != H_IDLE);
  assign stat_v = {8'h00, 7'h00, wp_n_r, rx_r, 7'h00, busy};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin : next_state
    logic [31:0] c1;
    c1 = merge(cmd1_r, w_d_r, w_s_r);
    st_nxt = st_r;
    aw_h_nxt = aw_h_r;
    aw_a_nxt = aw_a_r;
    w_h_nxt = w_h_r;
    w_d_nxt = w_d_r;
    w_s_nxt = w_s_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    cmd0_nxt = cmd0_r;
    cmd1_nxt = cmd1_r;
    wp_n_nxt = wp_n_r;
    tx_nxt = tx_r;
    bits_nxt = bits_r;
    rx_nxt = rx_r;
    div_nxt = tick ? 3'h0 : div_r + 3'h1;
    cs_n_nxt = cs_n_r;
    sclk_nxt = sclk_r;
    mosi_nxt = mosi_r;
    // Write address and data, either order
    if (awvalid && !aw_h_r) begin
      aw_h_nxt = 1'h1;
      aw_a_nxt = awaddr;
    end
    if (wvalid && !w_h_r) begin
      w_h_nxt = 1'h1;
      w_d_nxt = wdata;
      w_s_nxt = wstrb;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'h0;
    end
    if (aw_h_r && w_h_r && !bvalid_r) begin
      aw_h_nxt = 1'h0;
      w_h_nxt = 1'h0;
      bvalid_nxt = 1'h1;
      bresp_nxt = `SFWP_RESP_OKAY;
      case (aw_a_r)
        `SFWP_A_CMD0: cmd0_nxt = merge(cmd0_r, w_d_r, w_s_r);
        `SFWP_A_CMD1: begin
          cmd1_nxt = c1;
          if (!busy && c1[`SFWP_CMD1_BITS_LO +: 6] != 6'h00) begin
            tx_nxt = {cmd0_r, c1[7:0]};
            bits_nxt = c1[`SFWP_CMD1_BITS_LO +: 6];
            mosi_nxt = cmd0_r[31];
            cs_n_nxt = 1'h0;
            sclk_nxt = 1'h0;
            div_nxt = 3'h0;
            st_nxt = H_LEAD;
          end
        end
        // Pin raised before a lock-clearing status write [R15]
        `SFWP_A_WP: if (w_s_r[0]) wp_n_nxt = w_d_r[0];
        `SFWP_A_STAT: ;
        default: bresp_nxt = `SFWP_RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_h_nxt;
    wready_nxt = !w_h_nxt;
    // Read channel
    if (arvalid && arready_r) begin
      arready_nxt = 1'h0;
      rvalid_nxt = 1'h1;
      rresp_nxt = `SFWP_RESP_OKAY;
      case (araddr)
        `SFWP_A_CMD0: rdata_nxt = cmd0_r;
        `SFWP_A_CMD1: rdata_nxt = cmd1_r;
        `SFWP_A_STAT: rdata_nxt = stat_v;
        `SFWP_A_WP: rdata_nxt = {31'h00000000, wp_n_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = `SFWP_RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'h0;
      arready_nxt = 1'h1;
    end
    // Serial engine, one step per divider tick
    if (tick) begin
      case (st_r)
        H_IDLE: ;
        H_LEAD: st_nxt = H_SHIFT;
        H_SHIFT: begin
          if (!sclk_r) begin
            sclk_nxt = 1'h1;
            rx_nxt = {rx_r[6:0], ifc.miso_line};
            bits_nxt = bits_r - 6'h01;
          end else begin
            sclk_nxt = 1'h0;
            tx_nxt = {tx_r[38:0], 1'h0};
            mosi_nxt = tx_r[38];
            if (bits_r == 6'h00) begin
              st_nxt = H_TRAIL;
            end
          end
        end
        H_TRAIL: begin
          cs_n_nxt = 1'h1;
          st_nxt = H_IDLE;
        end
        default: st_nxt = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= H_IDLE;
      aw_h_r <= 1'h0;
      awready_r <= 1'h1;
      wready_r <= 1'h1;
      aw_a_r <= 4'h0;
      w_h_r <= 1'h0;
      w_d_r <= 32'h00000000;
      w_s_r <= 4'h0;
      bvalid_r <= 1'h0;
      bresp_r <= `SFWP_RESP_OKAY;
      arready_r <= 1'h1;
      rvalid_r <= 1'h0;
      rdata_r <= 32'h00000000;
      rresp_r <= `SFWP_RESP_OKAY;
      cmd0_r <= 32'h00000000;
      cmd1_r <= 32'h00000000;
      wp_n_r <= 1'h1;
      tx_r <= 40'h0000000000;
      bits_r <= 6'h00;
      rx_r <= 8'h00;
      div_r <= 3'h0;
      cs_n_r <= 1'h1;
      sclk_r <= 1'h0;
      mosi_r <= 1'h0;
    end else begin
      st_r <= st_nxt;
      aw_h_r <= aw_h_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_a_r <= aw_a_nxt;
      w_h_r <= w_h_nxt;
      w_d_r <= w_d_nxt;
      w_s_r <= w_s_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      cmd0_r <= cmd0_nxt;
      cmd1_r <= cmd1_nxt;
      wp_n_r <= wp_n_nxt;
      tx_r <= tx_nxt;
      bits_r <= bits_nxt;
      rx_r <= rx_nxt;
      div_r <= div_nxt;
      cs_n_r <= cs_n_nxt;
      sclk_r <= sclk_nxt;
      mosi_r <= mosi_nxt;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign ifc.cs_n = cs_n_r;
  assign ifc.sclk = sclk_r;
  assign ifc.mosi = mosi_r;
  assign ifc.wp_n = wp_n_r;

endmodule

// *** bench/sfwp_assertions.sv ***
// Checker for the protection link and the device state bits
// Assumes one aclk domain; placed beside the link in tb
`timescale 1ns/1ps
module sfwp_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link
  input wire logic cs_n,
  input wire logic wp_n,
  // Device state
  input wire logic write_latch_flag,
  input wire logic array_protect_bit,
  input wire logic protect_lock_bit,
  input wire logic hw_locked,
  input wire logic op_start,
  input wire logic nv_wr
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_lock_raise: assert property ((!wp_n && protect_lock_bit) |=> hw_locked)
    else $error("lock not raised");
  chk_lock_freeze: assert property ((!wp_n && protect_lock_bit) [*2]
    |=> $stable(array_protect_bit) && $stable(protect_lock_bit))
    else $error("locked bits changed");
  chk_latch_idle: assert property ($changed(write_latch_flag) |-> $past(cs_n))
    else $error("latch changed while selected");
  chk_latch_rise: assert property ($rose(write_latch_flag)
    |-> $past(cs_n, 1) && !$past(cs_n, 2))
    else $error("latch set at wrong time");
  chk_op_gate: assert property (op_start |-> $past(write_latch_flag))
    else $error("op without latch");
  chk_op_clear: assert property (op_start |-> !write_latch_flag)
    else $error("latch kept at op start");
  chk_nv_gate: assert property (nv_wr |-> $past(write_latch_flag)
    && !($past(protect_lock_bit) && !$past(wp_n)))
    else $error("status write not gated");
  chk_prot_path: assert property ($changed(array_protect_bit) |-> nv_wr)
    else $error("protect changed without write");
  chk_lock_clear: assert property ($fell(protect_lock_bit) |-> $past(wp_n))
    else $error("lock cleared with pin low");
  chk_pin_direct: assert property ($changed(wp_n) |=> $stable(array_protect_bit))
    else $error("pin moved protect bit");

  cov_latch: cover property ($rose(write_latch_flag));
  cov_op: cover property (op_start);
  cov_lock: cover property ($rose(hw_locked));
endmodule

// *** bench/tb.sv ***
// Testbench: AXI4-Lite host end driving the device end over the link
// Assumes the host register map and opcodes of sfwp_regs.svh
`timescale 1ns/1ps
`include "sfwp_regs.svh"
module tb;
  import sfwp_pkg::*;
  logic aclk, aresetn, op_done, nv_wr, nv_wr_val, op_start;
  logic nv_cell = 1'b0;
  sfwp_kind_e op_kind;
  logic [23:0] op_addr;
  logic write_latch_flag, array_protect_bit, protect_lock_bit, hw_locked;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int error_cnt = 0, total_checks = 0, n_ops = 0, cyc = 0;
  logic [7:0] ops [9] = '{8'h02, 8'h81, 8'h20, 8'h52, 8'hD8, 8'h60, 8'h62, 8'hC7, 8'h9B};

  sfwp_if u_sfwp_if ();
  sfwp_host u_sfwp_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ifc(u_sfwp_if));
  sfwp_device u_sfwp_device (.aclk(aclk), .aresetn(aresetn), .ifc(u_sfwp_if),
    .nv_prot_in(nv_cell), .nv_wr(nv_wr), .nv_wr_val(nv_wr_val), .op_start(op_start),
    .op_kind(op_kind), .op_addr(op_addr), .op_done(op_done),
    .write_latch_flag(write_latch_flag),
    .array_protect_bit(array_protect_bit), .protect_lock_bit(protect_lock_bit),
    .hw_locked(hw_locked));
  sfwp_assertions u_chk (.aclk(aclk), .aresetn(aresetn), .cs_n(u_sfwp_if.cs_n),
    .wp_n(u_sfwp_if.wp_n), .write_latch_flag(write_latch_flag),
    .array_protect_bit(array_protect_bit), .protect_lock_bit(protect_lock_bit),
    .hw_locked(hw_locked), .op_start(op_start), .nv_wr(nv_wr));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Nonvolatile cell, op completion, op count and timeout
  always @(posedge aclk) begin
    cyc++;
    op_done <= (op_start === 1'b1);
    if (op_start === 1'b1) n_ops++;
    if (nv_wr === 1'b1) nv_cell <= nv_wr_val;
    if (cyc == 60000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task do_reset;
    @(posedge aclk) aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask

  task send(input logic [31:0] c0, input logic [7:0] b4, input logic [5:0] n,
            output logic [31:0] s);
    axi_wr(`SFWP_A_CMD0, c0);
    axi_wr(`SFWP_A_CMD1, {18'h0, n, b4});
    repeat (2) @(posedge aclk);
    s = 32'h1;
    while (s[0] !== 1'b0) axi_rd(`SFWP_A_STAT, s);
    repeat (4) @(posedge aclk);
  endtask

  task cmd(input logic [7:0] op, input logic [5:0] n);
    logic [31:0] s;
    send({op, 24'hFFFFFF}, 8'hFF, n, s);
  endtask

  task swr(input logic [7:0] d);
    logic [31:0] s;
    cmd(`SFWP_OP_LATCH_SET, 6'd8);
    send({`SFWP_OP_STAT_WR, d, 16'hFFFF}, 8'hFF, 6'd16, s);
  endtask

  task t_latch;
    chk(write_latch_flag, 32'h0);
    chk(array_protect_bit, 32'h0);
    cmd(`SFWP_OP_LATCH_SET, 6'd8);
    chk(write_latch_flag, 32'h1);
    cmd(`SFWP_OP_LATCH_CLR, 6'd8);
    chk(write_latch_flag, 32'h0);
    cmd(`SFWP_OP_LATCH_SET, 6'd16);
    chk(write_latch_flag, 32'h1);
    cmd(`SFWP_OP_LATCH_CLR, 6'd7);
    chk(write_latch_flag, 32'h1);
    cmd(`SFWP_OP_LATCH_CLR, 6'd12);
    chk(write_latch_flag, 32'h1);
    cmd(`SFWP_OP_LATCH_CLR, 6'd24);
    chk(write_latch_flag, 32'h0);
    $display("latch test done");
  endtask

  task t_gate(input logic p);
    int n0;
    logic [5:0] n;
    logic [31:0] s;
    sfwp_kind_e k;
    n0 = n_ops;
    cmd(`SFWP_OP_CHIP_C, 6'd8);
    chk(n_ops - n0, 32'h0);
    for (int i = 0; i < 9; i++) begin
      n = (i == 0 || i == 8) ? 6'd40 : (i < 5) ? 6'd32 : 6'd8;
      cmd(`SFWP_OP_LATCH_SET, 6'd8);
      n0 = n_ops;
      send({ops[i], 24'h00FFFF}, 8'hAA, n, s);
      chk(n_ops - n0, (!p || i == 8) ? 32'h1 : 32'h0);
      chk(write_latch_flag, 32'h0);
      k = (i == 0) ? K_PROG : (i < 5) ? K_ERASE : (i < 8) ? K_CHIP : K_OTP;
      if (!p || i == 8) chk(op_kind, k);
      if ((!p && i < 5) || i == 8) chk(op_addr, 32'h00FFFF);
    end
    $display("gate test done");
  endtask

  task t_lock;
    logic [31:0] s;
    swr(8'h04);
    chk(array_protect_bit, 32'h1);
    t_gate(1'b1);
    swr(8'h84);
    chk({array_protect_bit, protect_lock_bit, hw_locked}, 32'h6);
    swr(8'h80);
    chk({array_protect_bit, protect_lock_bit}, 32'h1);
    axi_wr(`SFWP_A_WP, 32'h0);
    repeat (4) @(posedge aclk);
    chk({hw_locked, array_protect_bit}, 32'h2);
    swr(8'h04);
    chk({write_latch_flag, array_protect_bit, protect_lock_bit}, 32'h5);
    send({`SFWP_OP_STAT_RD, 24'h0}, 8'h0, 6'd16, s);
    chk(s[16:8], 32'h082);
    axi_wr(`SFWP_A_WP, 32'h1);
    swr(8'h00);
    chk({array_protect_bit, protect_lock_bit, hw_locked}, 32'h0);
    $display("lock test done");
  endtask

  task t_power;
    swr(8'h84);
    axi_wr(`SFWP_A_WP, 32'h0);
    repeat (4) @(posedge aclk);
    do_reset();
    repeat (2) @(posedge aclk);
    chk({write_latch_flag, array_protect_bit, protect_lock_bit}, 32'h2);
    $display("power test done");
  endtask

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    do_reset();
    t_latch();
    t_gate(1'b0);
    t_lock();
    t_power();
    report_and_stop();
  end
endmodule
